// file: hdl/rcoc_pkg.sv
package rcoc_pkg;
  // apb register byte offsets
  localparam logic [11:0] REG_CTRL     = 12'h000;  // validation enables
  localparam logic [11:0] REG_VLAN     = 12'h004;  // vlan tag type
  localparam logic [11:0] REG_LAST     = 12'h008;  // last frame result
  localparam logic [11:0] REG_INT_STS  = 12'h00C;  // sticky events, read only
  localparam logic [11:0] REG_INT_CLR  = 12'h010;  // write one to clear
  localparam logic [11:0] REG_INT_EN   = 12'h014;  // interrupt enables
  // control register bit positions
  localparam int unsigned CTRL_IP_BIT   = 0;
  localparam int unsigned CTRL_TU_BIT   = 1;
  localparam int unsigned CTRL_ICMP_BIT = 2;
  localparam int unsigned CTRL_IGMP_BIT = 3;
  localparam int unsigned CTRL_W        = 4;
  localparam logic [3:0]  CTRL_RST      = 4'h0;
  localparam logic [15:0] VLAN_RST      = 16'h8100;
  // interrupt event bit positions
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_IP   = 1;
  localparam int unsigned EV_L4   = 2;
  localparam int unsigned EV_W    = 3;
  // ethernet header layout
  localparam logic [3:0]  MAC_ADDR_LAST = 4'hB;    // 12 address bytes
  localparam logic [3:0]  VLAN_TCI_LEN  = 4'h2;
  localparam logic [3:0]  SNAP_LEN      = 4'h6;
  localparam logic [1:0]  VLAN_MAX      = 2'h2;
  localparam logic [15:0] ETH_MIN_TYPE  = 16'h0600; // below: length field
  localparam logic [15:0] ETH_IPV4      = 16'h0800;
  localparam logic [15:0] ETH_IPV6      = 16'h86DD;
  // ip header layout and protocol numbers
  localparam logic [5:0]  IP4_MIN_HDR   = 6'h14;
  localparam logic [15:0] IP6_HDR_LEN   = 16'h0028;
  localparam logic [7:0]  PR_HOP        = 8'h00;
  localparam logic [7:0]  PR_ICMP       = 8'h01;
  localparam logic [7:0]  PR_IGMP       = 8'h02;
  localparam logic [7:0]  PR_IPIP       = 8'h04;
  localparam logic [7:0]  PR_TCP        = 8'h06;
  localparam logic [7:0]  PR_UDP        = 8'h11;
  localparam logic [7:0]  PR_IP6        = 8'h29;
  localparam logic [7:0]  PR_ROUTE      = 8'h2B;
  localparam logic [7:0]  PR_FRAG       = 8'h2C;
  localparam logic [7:0]  PR_ICMP6      = 8'h3A;
  localparam logic [7:0]  PR_DEST       = 8'h3C;
  localparam logic [15:0] CSUM_GOOD     = 16'hFFFF;
  localparam int unsigned FCS_LEN       = 4;

  typedef enum logic [1:0] {
    E_ADDR = 2'b00, E_TYPE = 2'b01, E_SKIP = 2'b10, E_L3 = 2'b11
  } rcoc_eth_e;

  typedef enum logic [1:0] {
    K_NONE = 2'b00, K_IP4 = 2'b01, K_IP6 = 2'b10
  } rcoc_kind_e;

  typedef enum logic [2:0] {
    P_NONE = 3'b000, P_IP4 = 3'b001, P_IP6 = 3'b010, P_EXT = 3'b011, P_L4 = 3'b100
  } rcoc_pst_e;

  // one received byte with its framing marks
  typedef struct packed {
    logic [7:0] data;
    logic       sof;
    logic       eof;
  } rcoc_byte_s;

  // per-frame result handed to the fifo controller
  typedef struct packed {
    logic [15:0] raw_csum;
    logic        ip_checked;
    logic        ip_err;
    logic        l4_checked;
    logic        l4_err;
    logic        is_ipv6;
    logic        is_frag;
  } rcoc_status_s;

  // ethernet header walker state
  typedef struct packed {
    rcoc_eth_e  st;
    logic [3:0] cnt;
    logic [7:0] thi;
    logic [1:0] vlan_n;
    logic       snap;
    rcoc_kind_e kind;
  } rcoc_eth_s;

  // layer 3 walker state and running sums
  typedef struct packed {
    rcoc_pst_e   st;
    logic [15:0] idx;
    logic [15:0] hbase;
    logic [15:0] ip_end;
    logic [15:0] ext_end;
    logic [15:0] l4base;
    logic [5:0]  ihl;
    logic        mf;
    logic [12:0] foff;
    logic [7:0]  proto;
    logic        v4;
    logic        v6;
    logic        frag6;
    logic        tun4;
    logic        l4seen;
    logic [15:0] raw;
    logic [15:0] ipsum;
    logic [15:0] l4sum;
    logic [15:0] psum;
    logic [15:0] ucks;
  } rcoc_parse_s;

  localparam rcoc_eth_s   ETH_RST   = '{st: E_ADDR, kind: K_NONE, default: '0};
  localparam rcoc_parse_s PARSE_RST = '{st: P_NONE, default: '0};
endpackage : rcoc_pkg

// file: hdl/rcoc_check.sv
// Overview of operation
// - ip protocol 2 means igmp payload
// - igmp sum covers whole ip payload
// - igmp check only when enable bit set
// - fragments skip the igmp check
// - ipv6 walks hop, destination, routing headers
// - ipv6 fragment header: raw checksum only
// - snap and one or two vlans allowed
// - ipv6: no ip header, no igmp check
// - ipv4 fragment: ip check only, raw kept
// - options never block any check
// - other l4: ip check, no tcp/udp
// - non-ip frames: raw checksum only
// - v6 in v4: outer ip, inner l4
// - v4 in v4: raw checksum only
// - fragment is mf with zero offset, or offset
// - failing l4 sum sets its own l4 error bit, apart from the ip one
// - programmable vlan type, two tags skipped
module rcoc_check
  import rcoc_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  rst_n_i,
  // apb slave
  input  wire logic [11:0]           paddr_i,
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [31:0]           pwdata_i,
  output logic [31:0]                prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // receive byte stream from the mac
  input  wire logic                  rx_valid_i,
  input  wire rcoc_pkg::rcoc_byte_s  rx_i,
  output logic                       rx_ready_o,
  // byte stream and status toward the fifo controller
  output logic                       out_valid_o,
  output rcoc_pkg::rcoc_byte_s       out_o,
  output logic                       status_valid_o,
  output rcoc_pkg::rcoc_status_s     status_o,
  output logic                       irq_o
);
  import rcoc_pkg::*;

  // ones complement add with end-around carry
  function automatic logic [15:0] ocs_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'd0, s[16]};
  endfunction : ocs_add

  // byte placed in its network-order lane: even index is the high byte
  function automatic logic [15:0] lane(input logic [7:0] b, input logic odd);
    return odd ? {8'h00, b} : {b, 8'h00};
  endfunction : lane

  logic [CTRL_W-1:0] ctrl;         // validation enables
  logic [15:0]       vlan_type;    // tag type that marks a vlan
  logic [EV_W-1:0]   int_sts;      // sticky events
  logic [EV_W-1:0]   int_en;       // interrupt mask
  rcoc_status_s      last_st;      // result of the last frame
  logic [31:0]       rd_data;      // read data captured in setup
  logic              rd_err;       // unmapped address flag
  rcoc_eth_s         es;           // ethernet walker
  rcoc_eth_s         next_es;
  rcoc_parse_s       ps;           // l3 walker
  rcoc_parse_s       next_ps;
  logic [7:0]        dly_b [FCS_LEN];  // holds back the fcs
  logic [FCS_LEN-1:0] dly_v;
  logic              fin;          // cycle after the last byte
  logic              p1_v, p2_v;   // output stream pipeline
  rcoc_byte_s        p1, p2;
  rcoc_status_s      next_st;

  // apb decode
  wire apb_setup  = psel_i & ~penable_i;
  wire apb_wr     = psel_i & penable_i & pwrite_i;
  wire hit_ctrl   = (paddr_i == REG_CTRL);
  wire hit_vlan   = (paddr_i == REG_VLAN);
  wire hit_last   = (paddr_i == REG_LAST);
  wire hit_sts    = (paddr_i == REG_INT_STS);
  wire hit_clr    = (paddr_i == REG_INT_CLR);
  wire hit_en     = (paddr_i == REG_INT_EN);
  wire hit_any    = hit_ctrl | hit_vlan | hit_last | hit_sts | hit_clr | hit_en;
  wire [31:0] rd_mux =
      hit_ctrl ? {28'h000_0000, ctrl} :
      hit_vlan ? {16'h0000, vlan_type} :
      hit_last ? {10'h000, last_st} :
      hit_sts  ? {29'h0000_0000, int_sts} :
      hit_en   ? {29'h0000_0000, int_en} : 32'h0000_0000;

  // single-cycle access phase: the slave never stalls
  assign pready_o  = 1'b1;
  assign prdata_o  = rd_data;
  assign pslverr_o = rd_err;

  // stream handshake: one refused cycle after each frame so state can clear
  wire in_fire  = rx_valid_i & rx_ready_o;
  assign rx_ready_o = ~fin;
  wire l3_go    = in_fire & (es.st == E_L3);
  wire pv       = l3_go & dly_v[FCS_LEN-1];   // byte leaving the fcs hold-back
  wire [7:0] pb = dly_b[FCS_LEN-1];
  wire [15:0] h = ps.idx - ps.hbase;          // offset inside current header
  wire [15:0] rx_type = {es.thi, rx_i.data};

  // first l3 byte picks the walker state from the ethertype
  wire rcoc_pst_e kind_st = (es.kind == K_IP4) ? P_IP4 :
                            (es.kind == K_IP6) ? P_IP6 : P_NONE;
  wire rcoc_pst_e eff_st  = (ps.idx == 16'h0000) ? kind_st : ps.st;
  wire is_ext  = (ps.proto == PR_HOP) | (ps.proto == PR_ROUTE) | (ps.proto == PR_DEST);
  wire v4_last = (h != 16'h0000) & (h == {10'h000, ps.ihl} - 16'h0001);

  // ethernet header walker
  always_comb begin
    next_es = es;
    if (in_fire) begin
      unique case (es.st)
        E_ADDR: begin
          next_es.cnt = es.cnt + 4'h1;
          if (es.cnt == MAC_ADDR_LAST) begin
            next_es.st  = E_TYPE;
            next_es.cnt = 4'h0;
          end
        end
        E_TYPE: begin
          if (es.cnt == 4'h0) begin
            next_es.thi = rx_i.data;
            next_es.cnt = 4'h1;
          end else if (rx_type == vlan_type && es.vlan_n != VLAN_MAX) begin
            // tag is stepped over and kept out of every sum
            next_es.vlan_n = es.vlan_n + 2'h1;
            next_es.st     = E_SKIP;
            next_es.cnt    = VLAN_TCI_LEN;
          end else if (rx_type < ETH_MIN_TYPE && !es.snap) begin
            // llc/snap header hides the real type six bytes later
            next_es.snap = 1'b1;
            next_es.st   = E_SKIP;
            next_es.cnt  = SNAP_LEN;
          end else begin
            next_es.st   = E_L3;
            next_es.kind = (rx_type == ETH_IPV4) ? K_IP4 :
                           (rx_type == ETH_IPV6) ? K_IP6 : K_NONE;
          end
        end
        E_SKIP: begin
          next_es.cnt = es.cnt - 4'h1;
          if (es.cnt == 4'h1) begin
            next_es.st  = E_TYPE;
            next_es.cnt = 4'h0;
          end
        end
        E_L3: begin
          next_es.st = E_L3;
        end
      endcase
    end
  end

  // layer 3 walker and running sums
  always_comb begin
    logic disp6;
    disp6   = 1'b0;
    next_ps = ps;
    if (pv) begin
      next_ps.idx = ps.idx + 16'h0001;
      next_ps.raw = ocs_add(ps.raw, lane(pb, ps.idx[0]));
      next_ps.st  = eff_st;
      unique case (eff_st)
        P_IP4: begin
          if (h == 16'h0000) begin
            next_ps.ihl = {pb[3:0], 2'b00};
            next_ps.v4  = 1'b1;
          end
          if (h == 16'h0002) next_ps.ip_end = {pb, 8'h00};
          if (h == 16'h0003) next_ps.ip_end = ps.hbase + {ps.ip_end[15:8], pb};
          if (h == 16'h0006) begin
            next_ps.mf         = pb[5];
            next_ps.foff[12:8] = pb[4:0];
          end
          if (h == 16'h0007) next_ps.foff[7:0] = pb;
          if (h == 16'h0009) next_ps.proto = pb;
          if (h >= 16'h000C && h <= 16'h0013) next_ps.psum = ocs_add(ps.psum, lane(pb, ps.idx[0]));
          // header sum runs over every header word, options included
          if (h == 16'h0000 || h < {10'h000, ps.ihl}) next_ps.ipsum = ocs_add(ps.ipsum, lane(pb, ps.idx[0]));
          if (v4_last) begin
            next_ps.hbase  = ps.idx + 16'h0001;
            next_ps.l4base = ps.idx + 16'h0001;
            if (ps.proto == PR_IP6) begin
              next_ps.st   = P_IP6;
              next_ps.psum = 16'h0000;
            end else if (ps.proto == PR_IPIP) begin
              next_ps.tun4 = 1'b1;
              next_ps.st   = P_NONE;
            end else begin
              next_ps.st     = P_L4;
              next_ps.l4seen = 1'b1;
            end
          end
        end
        P_IP6: begin
          next_ps.v6 = 1'b1;
          if (h == 16'h0004) next_ps.ext_end = {pb, 8'h00};
          if (h == 16'h0005) next_ps.ip_end = ps.hbase + IP6_HDR_LEN + {ps.ext_end[15:8], pb};
          if (h == 16'h0006) next_ps.proto = pb;
          if (h >= 16'h0008 && h <= 16'h0027) next_ps.psum = ocs_add(ps.psum, lane(pb, ps.idx[0]));
          if (h == IP6_HDR_LEN - 16'h0001) disp6 = 1'b1;
        end
        P_EXT: begin
          // extension header: next header, then length in 8-byte units
          if (h == 16'h0000) next_ps.proto = pb;
          if (h == 16'h0001) next_ps.ext_end = ps.hbase + {5'h00, pb, 3'b000} + 16'h0008;
          if (h > 16'h0001 && ps.idx + 16'h0001 == ps.ext_end) disp6 = 1'b1;
        end
        P_L4: begin
          if (ps.idx < ps.ip_end) begin
            // whole ip payload, so igmp covers the full message
            next_ps.l4sum = ocs_add(ps.l4sum, lane(pb, ps.idx[0]));
            if (h == 16'h0006) next_ps.ucks[15:8] = pb;
            if (h == 16'h0007) next_ps.ucks[7:0]  = pb;
          end else begin
            next_ps.st = P_NONE;
          end
        end
        P_NONE: begin
          next_ps.st = P_NONE;
        end
      endcase
      // leave an ipv6 or extension header toward the next one
      if (disp6) begin
        next_ps.hbase  = ps.idx + 16'h0001;
        next_ps.l4base = ps.idx + 16'h0001;
        if (is_ext) begin
          next_ps.st = P_EXT;
        end else if (ps.proto == PR_FRAG) begin
          next_ps.frag6 = 1'b1;
          next_ps.st    = P_NONE;
        end else begin
          next_ps.st     = P_L4;
          next_ps.l4seen = 1'b1;
        end
      end
    end
  end

  // end-of-frame decision, taken from the walker after its last byte
  wire v4_frag = ps.v4 & ((ps.mf & (ps.foff == 13'h0000)) | (ps.foff != 13'h0000));
  wire frag    = v4_frag | ps.frag6;
  wire is_tcp  = (ps.proto == PR_TCP);
  wire is_udp  = (ps.proto == PR_UDP);
  wire is_icmp = ps.v6 ? (ps.proto == PR_ICMP6) : (ps.proto == PR_ICMP);
  wire is_igmp = ~ps.v6 & (ps.proto == PR_IGMP);
  wire [15:0] l4_len = ps.ip_end - ps.l4base;
  wire pseudo  = is_tcp | is_udp | (is_icmp & ps.v6);
  wire [15:0] tot = pseudo ?
      ocs_add(ocs_add(ocs_add(ps.l4sum, ps.psum), {8'h00, ps.proto}), l4_len) : ps.l4sum;
  wire udp_zero = is_udp & (ps.ucks == 16'h0000);
  // ipv4 in ipv4 and fragments never reach a layer 4
  wire l4_do = ps.l4seen & ~frag & ~ps.tun4 &
               (((is_tcp | is_udp) & ctrl[CTRL_TU_BIT]) |
                (is_icmp & ctrl[CTRL_ICMP_BIT]) |
                (is_igmp & ctrl[CTRL_IGMP_BIT]));
  // zero udp checksum means unused on ipv4, error on ipv6
  wire l4_bad = udp_zero ? ps.v6 : (tot != CSUM_GOOD);
  // outer ipv4 header is checked even for fragments and v6 tunnels
  wire ip_do  = ctrl[CTRL_IP_BIT] & ps.v4 & ~ps.tun4;
  wire ip_bad = (ps.ipsum != CSUM_GOOD) | (ps.ihl < IP4_MIN_HDR);

  always_comb begin
    next_st.raw_csum   = ps.raw;
    next_st.ip_checked = ip_do;
    next_st.ip_err     = ip_do & ip_bad;
    next_st.l4_checked = l4_do;
    next_st.l4_err     = l4_do & l4_bad;
    next_st.is_ipv6    = ps.v6;
    next_st.is_frag    = frag;
  end

  wire [EV_W-1:0] ev = fin ? {next_st.l4_err, next_st.ip_err, 1'b1} : '0;
  assign irq_o = |(int_sts & int_en);

  // apb registers; a new event wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl      <= CTRL_RST;
      vlan_type <= VLAN_RST;
      int_en    <= '0;
      int_sts   <= '0;
      rd_data   <= 32'h0000_0000;
      rd_err    <= 1'b0;
    end else begin
      if (apb_wr && hit_ctrl) ctrl <= pwdata_i[CTRL_W-1:0];
      if (apb_wr && hit_vlan) vlan_type <= pwdata_i[15:0];
      if (apb_wr && hit_en)   int_en <= pwdata_i[EV_W-1:0];
      int_sts <= (int_sts & ~((apb_wr && hit_clr) ? pwdata_i[EV_W-1:0] : '0)) | ev;
      if (apb_setup) begin
        rd_data <= rd_mux;
        rd_err  <= ~hit_any;
      end
    end
  end

  // frame walkers; everything returns to its start value after a frame
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      es  <= ETH_RST;
      ps  <= PARSE_RST;
      fin <= 1'b0;
    end else begin
      fin <= in_fire & rx_i.eof;
      es  <= fin ? ETH_RST : next_es;
      ps  <= fin ? PARSE_RST : next_ps;
    end
  end

  // fcs hold-back line: the last four bytes never reach a sum
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_v <= '0;
      for (int i = 0; i < FCS_LEN; i++) dly_b[i] <= 8'h00;
    end else if (fin) begin
      dly_v <= '0;
    end else if (l3_go) begin
      dly_v    <= {dly_v[FCS_LEN-2:0], 1'b1};
      dly_b[0] <= rx_i.data;
      for (int i = 1; i < FCS_LEN; i++) dly_b[i] <= dly_b[i-1];
    end
  end

  // two-stage stream pipe so the frame end meets its status
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      p1_v     <= 1'b0;
      p2_v     <= 1'b0;
      p1       <= '0;
      p2       <= '0;
      status_o <= '0;
      last_st  <= '0;
    end else begin
      p1_v <= in_fire;
      p1   <= rx_i;
      p2_v <= p1_v;
      p2   <= p1;
      if (fin) begin
        status_o <= next_st;
        last_st  <= next_st;
      end
    end
  end

  assign out_valid_o    = p2_v;
  assign out_o          = p2;
  assign status_valid_o = p2_v & p2.eof;
endmodule : rcoc_check

// file: verification/rcoc_check_assertions.sv
module rcoc_check_assertions
  import rcoc_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   rx_valid_i,
  input  wire rcoc_pkg::rcoc_byte_s   rx_i,
  input  wire logic                   rx_ready_o,
  input  wire logic                   out_valid_o,
  input  wire rcoc_pkg::rcoc_byte_s   out_o,
  input  wire logic                   status_valid_o,
  input  wire rcoc_pkg::rcoc_status_s status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // every taken byte comes out unchanged two cycles later
  a_byte_latency: assert property (
    rx_valid_i && rx_ready_o |-> ##2 out_valid_o && out_o == $past(rx_i, 2))
    else $error("taken byte not forwarded two cycles later");
  // the source is held off for exactly one cycle after a frame end
  a_ready_gap: assert property (
    rx_valid_i && rx_ready_o && rx_i.eof |=> !rx_ready_o ##1 rx_ready_o)
    else $error("ready gap after frame end is not one cycle");
  a_status_eof: assert property (
    status_valid_o |-> out_valid_o && out_o.eof)
    else $error("status strobe without the last byte");
  a_eof_status: assert property (
    out_valid_o && out_o.eof |-> status_valid_o)
    else $error("last byte left without its status");
  // status may only move together with the commit strobe
  a_status_hold: assert property (
    $changed(status_o) |-> status_valid_o)
    else $error("status changed between frames");
  a_frag_no_l4: assert property (
    status_valid_o && status_o.is_frag |-> !status_o.l4_checked)
    else $error("fragment got an upper layer check");
  a_l4_err_chk: assert property (
    status_valid_o && status_o.l4_err |-> status_o.l4_checked)
    else $error("upper layer error without a check");
  a_ip_err_chk: assert property (
    status_valid_o && !status_o.ip_checked |-> !status_o.ip_err)
    else $error("ip error flagged without ip check");

  c_l4_err: cover property (status_valid_o && status_o.l4_err);
  c_frag: cover property (status_valid_o && status_o.is_frag);
  c_full: cover property (status_valid_o && status_o.ip_checked && status_o.l4_checked);
endmodule : rcoc_check_assertions

// file: verification/rcoc_fifo_model.sv
// behavioural fifo controller: commits a frame when its status arrives
module rcoc_fifo_model
  import rcoc_pkg::*;
(
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  input  wire logic                   out_valid_i,
  input  wire rcoc_pkg::rcoc_byte_s   out_i,
  input  wire logic                   status_valid_i,
  input  wire rcoc_pkg::rcoc_status_s status_i,
  output int                          frames_o,
  output int                          len_o,
  output rcoc_pkg::rcoc_status_s      status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;  // bytes of the frame in flight

  // a status strobe without a byte is dropped, so a lost commit shows up
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt      <= 0;
      frames_o <= 0;
      len_o    <= 0;
      status_o <= '0;
    end else if (out_valid_i) begin
      cnt <= out_i.sof ? 1 : cnt + 1;
      if (status_valid_i) begin  // commit with the last byte
        frames_o <= frames_o + 1;
        len_o    <= out_i.sof ? 1 : cnt + 1;
        status_o <= status_i;
      end
    end
  end
endmodule : rcoc_fifo_model

// file: verification/tb_rcoc_check.sv
module tb_rcoc_check;
  timeunit 1ns;
  timeprecision 1ps;
  import rcoc_pkg::*;

  logic         ref_clk_i  = 1'h0;
  logic         rst_n_i    = 1'h0;  // active low
  logic         psel_i     = 1'h0;
  logic         penable_i  = 1'h0;
  logic         pwrite_i   = 1'h0;
  logic [11:0]  paddr_i    = 12'h000;
  logic [31:0]  pwdata_i   = 32'h0000_0000;
  logic         rx_valid_i = 1'h0;
  rcoc_byte_s   rx_i       = '0;
  logic [31:0]  prdata_o;
  logic         pready_o, pslverr_o, rx_ready_o, out_valid_o, status_valid_o, irq_o;
  rcoc_byte_s   out_o;
  rcoc_status_s status_o, fm_stat;
  int           fm_frames, fm_len;
  int           n_fail       = 0;
  int           total_checks = 0;
  logic [7:0]   fr[$];  // frame under construction

  always #10 ref_clk_i = ~ref_clk_i;

  rcoc_check u_rcoc_check (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rx_valid_i(rx_valid_i), .rx_i(rx_i), .rx_ready_o(rx_ready_o),
    .out_valid_o(out_valid_o), .out_o(out_o), .status_valid_o(status_valid_o), .status_o(status_o), .irq_o(irq_o));
  rcoc_fifo_model u_rcoc_fifo_model (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .out_valid_i(out_valid_o),
    .out_i(out_o), .status_valid_i(status_valid_o), .status_i(status_o), .frames_o(fm_frames), .len_o(fm_len),
    .status_o(fm_stat));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_stat(input rcoc_status_s got, input rcoc_status_s exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t status got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_stat

  // one apb transfer; an idle edge follows so the next setup never collides
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    psel_i    <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= wd;
    @(posedge ref_clk_i);
    penable_i <= 1'h1;
    do @(posedge ref_clk_i); while (pready_o !== 1'h1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'h0;
    penable_i <= 1'h0;
    @(posedge ref_clk_i);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'h1, a, d, rd, er);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic        er;
    apb(1'h0, a, 32'h0000_0000, rd, er);
    chk_word(rd, exp);
    chk_word({31'h0, er}, {31'h0, exp_err});
  endtask : rd_chk

  // irq is sampled mid-cycle, away from the edge that updates it
  task automatic chk_irq(input logic exp);
    @(negedge ref_clk_i);
    chk_word({31'h0, irq_o}, {31'h0, exp});
    @(posedge ref_clk_i);
  endtask : chk_irq

  // ones' complement sum of n bytes (n even), network order
  function automatic logic [15:0] ocs(input int s, input int n);
    logic [16:0] a;
    a = '0;
    for (int i = 0; i < n; i += 2) begin
      a = {1'h0, a[15:0]} + {1'h0, fr[s+i], fr[s+i+1]};
      a = {1'h0, a[15:0]} + {16'h0, a[16]};
    end
    return a[15:0];
  endfunction : ocs

  // the ready sample is taken mid-cycle, since inputs only move at edges
  task automatic send();
    logic rdy;
    for (int i = 0; i < fr.size(); i++) begin
      rx_i       <= '{data: fr[i], sof: (i == 0), eof: (i == fr.size() - 1)};
      rx_valid_i <= 1'h1;
      do begin
        @(negedge ref_clk_i);
        rdy = rx_ready_o;
        @(posedge ref_clk_i);
      end while (rdy !== 1'h1);
    end
    rx_valid_i <= 1'h0;
  endtask : send

  // builds an ip frame with an igmp body; e = {ip chk, l4 chk, l4 err, frag}
  task automatic run_frame(input logic [3:0] ctrl, input int nv, input logic [15:0] vt, input logic [15:0] et,
                           input logic [7:0] pr, input logic [15:0] fw, input int ihl, input int bad,
                           input logic [3:0] e);
    int           l3, hl, k, n0;
    logic [15:0]  c;
    rcoc_status_s ex;
    wr(REG_CTRL, 32'(ctrl));
    hl = 4 * ihl;
    fr.delete();
    for (int i = 0; i < 12; i++) fr.push_back(8'(i + 1));
    repeat (nv) fr = {fr, vt[15:8], vt[7:0], 8'h00, 8'h05};
    fr = {fr, et[15:8], et[7:0]};
    l3 = fr.size();
    fr = {fr, 8'(8'h40 + ihl), 8'h00, 8'h00, 8'(hl + 8), 8'h00, 8'h00, fw[15:8], fw[7:0], 8'h40, pr};
    fr = {fr, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h01, 8'h0A, 8'h00, 8'h00, 8'h02};
    repeat (hl - 20) fr.push_back(8'h01);
    fr = {fr, 8'h11, 8'h00, 8'h00, 8'h00, 8'hE0, 8'h00, 8'h00, 8'h01};
    c = ~ocs(l3, hl);
    fr[l3+10] = c[15:8];
    fr[l3+11] = c[7:0];
    c = ~ocs(l3 + hl, 8) ^ 16'(bad);
    fr[l3+hl+2] = c[15:8];
    fr[l3+hl+3] = c[7:0];
    ex = '{raw_csum: ocs(l3, hl + 8), ip_checked: e[3], ip_err: 1'h0, l4_checked: e[2], l4_err: e[1],
           is_ipv6: et == ETH_IPV6, is_frag: e[0]};
    fr = {fr, 8'hAA, 8'h55, 8'hAA, 8'h55};
    n0 = fm_frames;
    send();
    for (k = 0; k < 200 && fm_frames == n0; k++) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
    chk_word(32'(fm_frames), 32'(n0 + 1));
    chk_stat(fm_stat, ex);
    chk_word(32'(fm_len), 32'(fr.size()));  // whole frame delivered
    rd_chk(REG_LAST, 32'(ex), 1'h0);
    $display("frame test done, type %h proto %h", et, pr);
  endtask : run_frame

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    complete_run();
  end

  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'h1;
    @(posedge ref_clk_i);
    rd_chk(REG_CTRL, 32'h0000_0000, 1'h0);
    rd_chk(REG_VLAN, 32'h0000_8100, 1'h0);
    rd_chk(12'h020, 32'h0000_0000, 1'h1);
    $display("register test done");
    run_frame(4'hF, 0, 16'h8100, ETH_IPV4, PR_IGMP, 16'h0000, 5, 0, 4'hC);
    run_frame(4'hF, 0, 16'h8100, ETH_IPV4, PR_IGMP, 16'h0000, 5, 1, 4'hE);
    rd_chk(REG_INT_STS, 32'h0000_0005, 1'h0);
    wr(REG_INT_EN, 32'h0000_0004);
    chk_irq(1'h1);
    wr(REG_INT_CLR, 32'h0000_0004);
    chk_irq(1'h0);
    rd_chk(REG_INT_STS, 32'h0000_0001, 1'h0);
    wr(REG_INT_EN, 32'h0000_0001);
    chk_irq(1'h1);
    wr(REG_INT_CLR, 32'h0000_0007);
    chk_irq(1'h0);
    $display("interrupt test done");
    run_frame(4'h7, 0, 16'h8100, ETH_IPV4, PR_IGMP, 16'h0000, 5, 0, 4'h8);
    run_frame(4'hF, 0, 16'h8100, ETH_IPV4, PR_IGMP, 16'h2000, 5, 0, 4'h9);
    run_frame(4'hF, 0, 16'h8100, ETH_IPV4, PR_IGMP, 16'h0001, 5, 0, 4'h9);
    run_frame(4'hF, 0, 16'h8100, 16'h0806, PR_IGMP, 16'h0000, 5, 0, 4'h0);
    run_frame(4'hF, 0, 16'h8100, ETH_IPV4, PR_IPIP, 16'h0000, 5, 0, 4'h0);
    run_frame(4'hF, 0, 16'h8100, ETH_IPV6, PR_IGMP, 16'h0000, 5, 0, 4'h0);
    run_frame(4'hF, 0, 16'h8100, ETH_IPV4, 8'h33, 16'h0000, 5, 0, 4'h8);
    run_frame(4'hF, 0, 16'h8100, ETH_IPV4, PR_IGMP, 16'h0000, 6, 0, 4'hC);
    run_frame(4'hF, 1, 16'h8100, ETH_IPV4, PR_IGMP, 16'h0000, 5, 0, 4'hC);
    wr(REG_VLAN, 32'h0000_9100);
    run_frame(4'hF, 2, 16'h9100, ETH_IPV4, PR_IGMP, 16'h0000, 5, 0, 4'hC);
    complete_run();
  end
endmodule : tb_rcoc_check

bind rcoc_check rcoc_check_assertions u_rcoc_check_assertions (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .rx_valid_i(rx_valid_i), .rx_i(rx_i), .rx_ready_o(rx_ready_o), .out_valid_o(out_valid_o), .out_o(out_o),
  .status_valid_o(status_valid_o), .status_o(status_o));
